// ### design/capture_qualifier.sv
// Purpose: capture unit with storage qualification and basic trigger
// Assumes: monitored inputs synchronous to clock
// Notes: two levels of groups; leaves grouped by a fixed map
`timescale 1ns/1ps
`default_nettype none
module capture_qualifier #(
	parameter int N_SIG = 8,
	parameter int BUS_W = 8,
	parameter int N_LEAF_GRP = 4,
	parameter logic [1:0] QUAL_MODE = capture_pkg::QUAL_STATE
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [capture_pkg::SAMPLE_W-1:0] probe_data,
	input wire logic [N_SIG-1:0] trig_sig,
	input wire logic [BUS_W-1:0] trig_bus,
	input wire logic acq_start,
	input wire logic acq_abort,
	input wire logic qual_bypass,
	input wire logic record_gaps,
	input wire logic use_groups,
	input wire logic [3*N_SIG-1:0] sig_pattern,
	input wire logic [N_SIG-1:0] sig_enable,
	input wire logic [BUS_W-1:0] bus_value,
	input wire logic [BUS_W-1:0] bus_care,
	input wire logic bus_enable,
	input wire logic [N_LEAF_GRP-1:0] leaf_is_or,
	input wire logic [N_LEAF_GRP-1:0] leaf_force_en,
	input wire logic [N_LEAF_GRP-1:0] leaf_force_val,
	input wire capture_pkg::group_cfg_s top_cfg,
	input wire logic start_store,
	input wire logic stop_store,
	input wire logic start_cond,
	input wire logic stop_cond,
	output logic sample_valid,
	input wire logic sample_ready,
	output capture_pkg::sample_s sample_out,
	output logic acq_active,
	output logic triggered,
	output logic store_active
);
	// ----------------------------------------------------------------
	// Trigger evaluation
	// ----------------------------------------------------------------
	capture_pkg::acq_state_e state;
	logic [N_SIG-1:0] prev_sig;
	logic [N_SIG-1:0] sig_match;
	logic bus_match;
	logic [N_LEAF_GRP-1:0] leaf_val;
	logic top_red;
	logic top_val;
	logic trig_hit;
	logic running;
	logic buf_ready;
	assign running = (state == capture_pkg::ST_RUN);
	// No reset: the first edge after reset compares against live data, so no false edge appears
	always_ff @(posedge clock) begin
		prev_sig <= trig_sig;
	end
	always_comb begin
		for (int i = 0; i < N_SIG; i++) begin
			case (sig_pattern[3*i +: 3])
				capture_pkg::PAT_IGNORE: sig_match[i] = 1'b1;
				capture_pkg::PAT_LOW: sig_match[i] = !trig_sig[i];
				capture_pkg::PAT_HIGH: sig_match[i] = trig_sig[i];
				capture_pkg::PAT_FALL: sig_match[i] = prev_sig[i] && !trig_sig[i];
				capture_pkg::PAT_RISE: sig_match[i] = !prev_sig[i] && trig_sig[i];
				capture_pkg::PAT_EITHER: sig_match[i] = prev_sig[i] ^ trig_sig[i];
				default: sig_match[i] = 1'b1;
			endcase
			if (!sig_enable[i]) begin
				sig_match[i] = 1'b1;
			end
		end
	end
	// Cleared care bits drop out of the compare
	assign bus_match = !bus_enable || (((trig_bus ^ bus_value) & bus_care) == '0);
	// Leaf groups: signal i belongs to group i mod N_LEAF_GRP; the map is fixed so only hierarchy shapes logic
	always_comb begin
		for (int g = 0; g < N_LEAF_GRP; g++) begin
			logic a;
			logic o;
			a = 1'b1;
			o = 1'b0;
			for (int i = 0; i < N_SIG; i++) begin
				if ((i % N_LEAF_GRP) == g && sig_enable[i]) begin
					a = a & sig_match[i];
					o = o | sig_match[i];
				end
			end
			leaf_val[g] = leaf_is_or[g] ? o : a;
			if (leaf_force_en[g]) begin
				leaf_val[g] = leaf_force_val[g];
			end
		end
	end
	always_comb begin
		case (top_cfg.reduce)
			capture_pkg::RED_AND: top_red = &leaf_val;
			capture_pkg::RED_OR: top_red = |leaf_val;
			capture_pkg::RED_NAND: top_red = ~&leaf_val;
			capture_pkg::RED_NOR: top_red = ~|leaf_val;
			capture_pkg::RED_XOR: top_red = ^leaf_val;
			capture_pkg::RED_XNOR: top_red = ~^leaf_val;
			capture_pkg::RED_TRUE: top_red = 1'b1;
			capture_pkg::RED_FALSE: top_red = 1'b0;
			default: top_red = 1'b0;
		endcase
		top_val = top_cfg.force_en ? top_cfg.force_val : top_red;
	end
	// All conditions are ports, so a new pattern needs no rebuild
	assign trig_hit = use_groups ? top_val : ((&sig_match) && bus_match);
	// ----------------------------------------------------------------
	// Acquisition control
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= capture_pkg::ST_IDLE;
		end else begin
			case (state)
				capture_pkg::ST_IDLE: begin
					if (acq_start) begin
						state <= capture_pkg::ST_RUN;
					end
				end
				capture_pkg::ST_RUN: begin
					if (acq_abort || (trig_hit && buf_ready)) begin
						state <= capture_pkg::ST_DONE;
					end
				end
				capture_pkg::ST_DONE: begin
					if (acq_start) begin
						state <= capture_pkg::ST_RUN;
					end
				end
				default: state <= capture_pkg::ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Storage qualification
	// ----------------------------------------------------------------
	logic storing;
	logic store_now;
	logic paused;
	logic begin_cmd;
	logic end_cmd;
	// Build-time mode picks which commands drive the qualifier
	assign begin_cmd = (QUAL_MODE == capture_pkg::QUAL_STATE) ? start_store : start_cond;
	assign end_cmd = (QUAL_MODE == capture_pkg::QUAL_STATE) ? stop_store : stop_cond;
	always_comb begin
		if (qual_bypass || QUAL_MODE == capture_pkg::QUAL_CONTINUOUS) begin
			store_now = running;
		end else if (storing) begin
			store_now = running;
		end else begin
			store_now = running && begin_cmd;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			storing <= 1'b0;
		end else if (!running) begin
			storing <= 1'b0;
		end else if (storing) begin
			if (end_cmd) begin
				storing <= 1'b0;
			end
		end else if (begin_cmd && !end_cmd) begin
			storing <= 1'b1;
		end
	end
	// A skipped cycle marks the next stored sample as following a gap
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			paused <= 1'b0;
		end else if (!running) begin
			paused <= 1'b0;
		end else if (store_now && buf_ready) begin
			paused <= 1'b0;
		end else begin
			paused <= 1'b1;
		end
	end
	capture_pkg::sample_s next_sample;
	always_comb begin
		next_sample.data = probe_data;
		next_sample.trig = trig_hit;
		next_sample.gap = record_gaps && paused;
	end
	// Samples refused by a full buffer are dropped but flagged as a gap
	skid_buffer #(
		.WIDTH($bits(capture_pkg::sample_s)),
		.DEPTH(2)
	) u_buf (
		.clock(clock),
		.rst_b(rst_b),
		.in_valid(store_now),
		.in_ready(buf_ready),
		.in_data(next_sample),
		.out_valid(sample_valid),
		.out_ready(sample_ready),
		.out_data(sample_out)
	);
	assign acq_active = running;
	assign triggered = (state == capture_pkg::ST_DONE);
	assign store_active = storing;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_no_store_before_begin;
		@(posedge clock) disable iff (!rst_b)
		(QUAL_MODE == capture_pkg::QUAL_STATE && !qual_bypass && running && !storing && !start_store) |-> !store_now;
	endproperty
	a_no_store_before_begin: assert property (p_no_store_before_begin) else $error("store before begin");
	property p_end_pauses;
		@(posedge clock) disable iff (!rst_b)
		(QUAL_MODE != capture_pkg::QUAL_CONTINUOUS && storing && end_cmd && running && !acq_abort && !trig_hit
			&& !qual_bypass && !begin_cmd) ##1 (!qual_bypass && !begin_cmd) |-> !store_now && running;
	endproperty
	a_end_pauses: assert property (p_end_pauses) else $error("end did not pause");
	property p_single_sample;
		@(posedge clock) disable iff (!rst_b)
		(QUAL_MODE != capture_pkg::QUAL_CONTINUOUS && !storing && running && begin_cmd && end_cmd && !qual_bypass
			&& !trig_hit && !acq_abort) ##1 (!begin_cmd && !qual_bypass) |-> !store_now && $past(store_now);
	endproperty
	a_single_sample: assert property (p_single_sample) else $error("not one sample");
	property p_gap_flag;
		@(posedge clock) disable iff (!rst_b)
		(running && record_gaps && !(store_now && buf_ready) && !acq_abort && !(trig_hit && buf_ready))
			|=> next_sample.gap == record_gaps;
	endproperty
	a_gap_flag: assert property (p_gap_flag) else $error("gap not flagged");
	property p_bypass;
		@(posedge clock) disable iff (!rst_b)
		(qual_bypass && running) |-> store_now;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not storing");
	property p_stop_on_trigger;
		@(posedge clock) disable iff (!rst_b)
		(running && trig_hit && buf_ready) |=> triggered && !acq_active;
	endproperty
	a_stop_on_trigger: assert property (p_stop_on_trigger) else $error("no stop on trigger");
	property p_keep_running;
		@(posedge clock) disable iff (!rst_b)
		(running && !trig_hit && !acq_abort) |=> running;
	endproperty
	a_keep_running: assert property (p_keep_running) else $error("stopped early");
	property p_rise_edge;
		@(posedge clock) disable iff (!rst_b)
		(sig_pattern[2:0] == capture_pkg::PAT_RISE && sig_enable[0] && !$past(trig_sig[0]) && trig_sig[0]) |-> sig_match[0];
	endproperty
	a_rise_edge: assert property (p_rise_edge) else $error("rise missed");
	property p_force;
		@(posedge clock) disable iff (!rst_b)
		(use_groups && top_cfg.force_en) |-> trig_hit == top_cfg.force_val;
	endproperty
	a_force: assert property (p_force) else $error("force ignored");
	property p_store_on_begin;
		@(posedge clock) disable iff (!rst_b)
		(running && begin_cmd && !storing) |-> store_now;
	endproperty
	a_store_on_begin: assert property (p_store_on_begin) else $error("begin did not store");
	property p_hold_storing;
		@(posedge clock) disable iff (!rst_b)
		(running && storing && !end_cmd) |=> storing;
	endproperty
	a_hold_storing: assert property (p_hold_storing) else $error("storing dropped without end");
	property p_triggered_holds;
		@(posedge clock) disable iff (!rst_b)
		(triggered && !acq_start) |=> triggered && !store_now;
	endproperty
	a_triggered_holds: assert property (p_triggered_holds) else $error("capture not held");
	property p_ignore;
		@(posedge clock) disable iff (!rst_b)
		(!sig_enable[0] || sig_pattern[2:0] == capture_pkg::PAT_IGNORE) |-> sig_match[0];
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored signal blocks match");
	property p_low_level;
		@(posedge clock) disable iff (!rst_b)
		(sig_enable[0] && sig_pattern[2:0] == capture_pkg::PAT_LOW) |-> sig_match[0] == !trig_sig[0];
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level wrong");
	property p_fall_edge;
		@(posedge clock) disable iff (!rst_b)
		(sig_enable[0] && sig_pattern[2:0] == capture_pkg::PAT_FALL)
			|-> sig_match[0] == ($past(trig_sig[0]) && !trig_sig[0]);
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("fall wrong");
	property p_either_no_edge;
		@(posedge clock) disable iff (!rst_b)
		(sig_enable[0] && sig_pattern[2:0] == capture_pkg::PAT_EITHER && trig_sig[0] == $past(trig_sig[0]))
			|-> !sig_match[0];
	endproperty
	a_either_no_edge: assert property (p_either_no_edge) else $error("edge seen without change");
	property p_bus_care;
		@(posedge clock) disable iff (!rst_b)
		(!use_groups && bus_enable && trig_hit) |-> ((trig_bus & bus_care) == (bus_value & bus_care));
	endproperty
	a_bus_care: assert property (p_bus_care) else $error("bus cared bits differ");
	property p_bus_dont_care;
		@(posedge clock) disable iff (!rst_b)
		(bus_care == '0) |-> bus_match;
	endproperty
	a_bus_dont_care: assert property (p_bus_dont_care) else $error("dont care bits compared");
	property p_basic_and;
		@(posedge clock) disable iff (!rst_b)
		(!use_groups && trig_hit) |-> (&sig_match);
	endproperty
	a_basic_and: assert property (p_basic_and) else $error("basic trigger without all matches");
	property p_leaf_and;
		@(posedge clock) disable iff (!rst_b)
		(!leaf_is_or[0] && !leaf_force_en[0] && sig_enable[0] && !sig_match[0]) |-> !leaf_val[0];
	endproperty
	a_leaf_and: assert property (p_leaf_and) else $error("and group set");
	property p_leaf_or;
		@(posedge clock) disable iff (!rst_b)
		(leaf_is_or[0] && !leaf_force_en[0] && sig_enable[0] && sig_match[0]) |-> leaf_val[0];
	endproperty
	a_leaf_or: assert property (p_leaf_or) else $error("or group clear");
	property p_leaf_force;
		@(posedge clock) disable iff (!rst_b)
		leaf_force_en[0] |-> (leaf_val[0] == leaf_force_val[0]);
	endproperty
	a_leaf_force: assert property (p_leaf_force) else $error("leaf force ignored");
	property p_top_and;
		@(posedge clock) disable iff (!rst_b)
		(use_groups && !top_cfg.force_en && top_cfg.reduce == capture_pkg::RED_AND && trig_hit)
			|-> (&leaf_val);
	endproperty
	a_top_and: assert property (p_top_and) else $error("top and wrong");
	property p_top_nor;
		@(posedge clock) disable iff (!rst_b)
		(use_groups && !top_cfg.force_en && top_cfg.reduce == capture_pkg::RED_NOR && trig_hit)
			|-> (leaf_val == '0);
	endproperty
	a_top_nor: assert property (p_top_nor) else $error("top nor wrong");
	property p_top_true;
		@(posedge clock) disable iff (!rst_b)
		(use_groups && !top_cfg.force_en && top_cfg.reduce == capture_pkg::RED_TRUE) |-> trig_hit;
	endproperty
	a_top_true: assert property (p_top_true) else $error("top true wrong");
	c_trigger: cover property (@(posedge clock) disable iff (!rst_b) running ##1 triggered);
	c_gap: cover property (@(posedge clock) disable iff (!rst_b) sample_valid && sample_out.gap);
	c_full: cover property (@(posedge clock) disable iff (!rst_b) running && !buf_ready);
	c_single: cover property (@(posedge clock) disable iff (!rst_b) running && !storing && start_store && stop_store);
	c_group: cover property (@(posedge clock) disable iff (!rst_b) running && use_groups && !top_cfg.force_en && trig_hit);
endmodule // capture_qualifier
`default_nettype wire

// ### design/capture_pkg.sv
// Purpose: constants and types for the capture trigger qualifier
// Assumes: single 50 MHz clock, synchronous active-low reset
// Notes: run-time fields arrive as plain ports
//
// Functional notes
// - With state-machine qualification, nothing is stored until begin-storing runs.
// - End-storing pauses buffer writes; acquisition stays active.
// - Begin and end in one cycle store exactly one sample.
// - With discontinuity marking on, flag samples stored right after a pause.
// - Run-time bypass disables qualification and stores every cycle.
// - Qualification mode is a build parameter; only bypass changes at run time.
// - After start, sample continuously until the trigger condition holds.
// - Each trigger signal takes ignore, low, high, fall, rise or either edge.
// - Bus triggers compare to a pattern with don't-care bit positions.
// - Conjunctive trigger stops capture when all enabled signals match together.
// - Nested groups evaluate bottom-up, leaves first, parents from children.
// - A forced group value overrides its members' values.
// - Parent groups reduce by AND, OR, NAND, NOR, XOR, XNOR, true or false.
// - Bottom-level groups support only AND and OR.
// - Structure depends only on hierarchy, not sibling arrangement.
// - Condition values load at run time; new signals need a rebuild.
// - Under start/stop qualification, extra starts are ignored until stop.
package capture_pkg;
	localparam int CLOCK_HZ = 50000000;
	localparam logic [2:0] PAT_IGNORE = 3'h0;
	localparam logic [2:0] PAT_LOW = 3'h1;
	localparam logic [2:0] PAT_HIGH = 3'h2;
	localparam logic [2:0] PAT_FALL = 3'h3;
	localparam logic [2:0] PAT_RISE = 3'h4;
	localparam logic [2:0] PAT_EITHER = 3'h5;
	localparam logic [2:0] RED_AND = 3'h0;
	localparam logic [2:0] RED_OR = 3'h1;
	localparam logic [2:0] RED_NAND = 3'h2;
	localparam logic [2:0] RED_NOR = 3'h3;
	localparam logic [2:0] RED_XOR = 3'h4;
	localparam logic [2:0] RED_XNOR = 3'h5;
	localparam logic [2:0] RED_TRUE = 3'h6;
	localparam logic [2:0] RED_FALSE = 3'h7;
	localparam logic [1:0] QUAL_CONTINUOUS = 2'h0;
	localparam logic [1:0] QUAL_START_STOP = 2'h1;
	localparam logic [1:0] QUAL_STATE = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_DONE = 2'h2
	} acq_state_e;
	typedef struct packed {
		logic [2:0] reduce;
		logic force_en;
		logic force_val;
	} group_cfg_s;
	localparam int SAMPLE_W = 16;
	typedef struct packed {
		logic gap;
		logic trig;
		logic [SAMPLE_W-1:0] data;
	} sample_s;
endpackage

// ### design/skid_buffer.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes: full accepts nothing; a stalled drain fills it
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [$clog2(DEPTH):0] count;
	logic [$clog2(DEPTH)-1:0] rd;
	logic [$clog2(DEPTH)-1:0] wr;
	logic push;
	logic pop;
	assign in_ready = (count != ($clog2(DEPTH)+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			count <= '0;
			rd <= '0;
			wr <= '0;
		end else begin
			if (push) begin
				wr <= ($clog2(DEPTH))'((wr + 1'b1) % DEPTH);
			end
			if (pop) begin
				rd <= ($clog2(DEPTH))'((rd + 1'b1) % DEPTH);
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr] <= in_data;
		end
	end
endmodule // skid_buffer
`default_nettype wire

// ### testbench/capture_reader.sv
// Purpose: host-side reader that drains captured samples
// Assumes: stall is driven by the bench just after the sampling edge
// Notes: ready stays low in reset, so no word is taken early
`timescale 1ns/1ps
`default_nettype none
module capture_reader (
	input wire logic rst_b,
	input wire logic stall,
	output logic sample_ready
);
	// ----
	// Drain
	// ----
	// Combinational, so a stall lands in the cycle it is asked for
	always_comb begin
		sample_ready = rst_b && !stall;
	end
endmodule // capture_reader
`default_nettype wire

// ### testbench/tb_capture_qualifier.sv
// Purpose: self-checking bench for capture_qualifier
// Assumes: state-mode qualifier build; reader model on the sample port
// Notes: a cycle model predicts each stored word; a monitor checks them in order
`timescale 1ns/1ps
`default_nettype none
module tb_capture_qualifier;
	// ----
	// Signals
	// ----
	logic clock = 1'b0, rst_b = 1'b0, stall = 1'b0, acq_start = 1'b0, qual_bypass = 1'b0, record_gaps = 1'b1;
	logic use_groups = 1'b0, bus_enable = 1'b0, start_store = 1'b0, stop_store = 1'b0;
	logic [15:0] probe_data = 16'h0000;
	logic [7:0] trig_sig = 8'h00, trig_bus = 8'h00, sig_enable = 8'h00, bus_value = 8'h00, bus_care = 8'h00;
	logic [23:0] sig_pattern = 24'h000000;
	logic [3:0] leaf_is_or = 4'h0, leaf_force_en = 4'h0, leaf_force_val = 4'h0;
	capture_pkg::group_cfg_s top_cfg = '0;
	logic sample_valid, sample_ready, acq_active, triggered, store_active;
	capture_pkg::sample_s sample_out;
	capture_pkg::sample_s exp_q[$];
	int fail_count = 0, total_checks = 0, seed = 86102, occ = 0, store_mode = 0, stall_mode = 0, k, n;
	logic running = 1'b0, done = 1'b0, storing = 1'b0, miss = 1'b0, rnd_trig = 1'b0, hit, push, pop;
	logic [7:0] prev = 8'h00;

	initial forever #10 clock = ~clock;

	capture_qualifier u_capture_qualifier (.clock(clock), .rst_b(rst_b), .probe_data(probe_data),
		.trig_sig(trig_sig), .trig_bus(trig_bus), .acq_start(acq_start), .acq_abort(1'b0),
		.qual_bypass(qual_bypass), .record_gaps(record_gaps), .use_groups(use_groups),
		.sig_pattern(sig_pattern), .sig_enable(sig_enable), .bus_value(bus_value), .bus_care(bus_care),
		.bus_enable(bus_enable), .leaf_is_or(leaf_is_or), .leaf_force_en(leaf_force_en),
		.leaf_force_val(leaf_force_val), .top_cfg(top_cfg), .start_store(start_store),
		.stop_store(stop_store), .start_cond(1'b0), .stop_cond(1'b0), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_out(sample_out), .acq_active(acq_active),
		.triggered(triggered), .store_active(store_active));
	capture_reader u_capture_reader (.rst_b(rst_b), .stall(stall), .sample_ready(sample_ready));

	// ----
	// Checking
	// ----
	task automatic chk_bit(string what, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_sample(string what, capture_pkg::sample_s e, capture_pkg::sample_s g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic pm(logic [2:0] c, logic cu, logic pv);
		case (c)
			capture_pkg::PAT_LOW: return !cu;
			capture_pkg::PAT_HIGH: return cu;
			capture_pkg::PAT_FALL: return pv && !cu;
			capture_pkg::PAT_RISE: return !pv && cu;
			capture_pkg::PAT_EITHER: return pv != cu;
			default: return 1'b1;
		endcase
	endfunction
	function automatic logic cond_now();
		logic [3:0] lg;
		logic r;
		logic m;
		r = 1'b1;
		lg = ~leaf_is_or;
		for (int i = 0; i < 8; i++) begin
			m = pm(sig_pattern[3*i +: 3], trig_sig[i], prev[i]);
			if (sig_enable[i]) begin
				r = r & m;
				lg[i%4] = leaf_is_or[i%4] ? (lg[i%4] | m) : (lg[i%4] & m);
			end
		end
		if (!use_groups) begin
			return r && (!bus_enable || ((trig_bus ^ bus_value) & bus_care) == 8'h00);
		end
		lg = (lg & ~leaf_force_en) | (leaf_force_val & leaf_force_en);
		case (top_cfg.reduce)
			capture_pkg::RED_AND: r = &lg;
			capture_pkg::RED_OR: r = |lg;
			capture_pkg::RED_NAND: r = ~&lg;
			capture_pkg::RED_NOR: r = ~|lg;
			capture_pkg::RED_XOR: r = ^lg;
			capture_pkg::RED_XNOR: r = ~^lg;
			capture_pkg::RED_TRUE: r = 1'b1;
			default: r = 1'b0;
		endcase
		return top_cfg.force_en ? top_cfg.force_val : r;
	endfunction

	// Cycle model: sees the inputs the design samples at this edge
	always @(posedge clock) begin
		if (!rst_b) begin
			running = 1'b0; done = 1'b0; storing = 1'b0; miss = 1'b0; occ = 0;
			exp_q.delete();
		end else begin
			chk_bit("acq_active", running, acq_active);
			chk_bit("triggered", done, triggered);
			if (running) chk_bit("store_active", storing, store_active);
			hit = running && occ < 2 && cond_now();
			push = running && occ < 2 && (qual_bypass || storing || start_store);
			pop = occ > 0 && sample_ready;
			if (push) exp_q.push_back(capture_pkg::sample_s'({record_gaps && miss, hit, probe_data}));
			if (push) miss = 1'b0;
			else if (running) miss = 1'b1;
			occ = occ + int'(push) - int'(pop);
			if (running) storing = (start_store && !stop_store) ? 1'b1 : (stop_store ? 1'b0 : storing);
			if (hit) begin
				running = 1'b0; done = 1'b1;
			end else if (acq_start && !running) begin
				running = 1'b1; done = 1'b0; storing = 1'b0; miss = 1'b0;
			end
		end
		prev = trig_sig;
	end
	// Monitor: one note off the queue per word the reader takes
	always @(posedge clock) begin
		if (rst_b && sample_valid === 1'b1 && sample_ready) begin
			if (exp_q.size() == 0) chk_bit("unexpected sample", 1'b0, 1'b1);
			else chk_sample("sample_out", exp_q.pop_front(), sample_out);
		end
	end

	// ----
	// Stimulus
	// ----
	always @(posedge clock) begin
		probe_data <= 16'($random(seed));
		trig_sig <= rnd_trig ? 8'($random(seed)) : 8'h00;
		trig_bus <= 8'($random(seed));
		stall <= stall_mode == 2 || (stall_mode == 1 && ($random(seed) & 3) == 0);
		start_store <= store_mode == 2 || (store_mode == 1 && ($random(seed) & 7) == 0);
		stop_store <= store_mode == 2 || (store_mode == 1 && ($random(seed) & 7) == 0);
	end
	task automatic cyc(int c);
		repeat (c) @(posedge clock);
	endtask
	task automatic start_acq;
		@(posedge clock) acq_start <= 1'b1;
		@(posedge clock) acq_start <= 1'b0;
	endtask
	// The model's flags are read at the falling edge, where they have settled
	task automatic wait_done(int lim);
		for (n = 0; n < lim; n++) begin
			@(negedge clock);
			if (done) break;
		end
		@(posedge clock);
	endtask
	// Slow configurations fall back to a forced top group loaded mid-run
	task automatic force_trig;
		if (!done) begin
			use_groups <= 1'b1;
			top_cfg <= '{capture_pkg::RED_FALSE, 1'b1, 1'b1};
		end
		wait_done(10);
		cyc(1);
	endtask
	task automatic run_trig;
		start_acq();
		wait_done(40);
		force_trig();
	endtask
	initial begin
		#(20 * 6000);
		chk_bit("watchdog", 1'b0, 1'b1);
		finish_test();
	end
	initial begin
		cyc(16);
		rst_b <= 1'b1;
		sig_enable <= 8'h01;
		sig_pattern <= {21'h0, capture_pkg::PAT_HIGH};
		run_trig();
		use_groups <= 1'b0;
		top_cfg <= '0;
		start_acq();
		store_mode <= 2; cyc(1);
		store_mode <= 1; stall_mode <= 1; cyc(60);
		qual_bypass <= 1'b1; cyc(30);
		stall_mode <= 2; cyc(8);
		stall_mode <= 0; cyc(6);
		record_gaps <= 1'b0; stall_mode <= 1; cyc(20);
		record_gaps <= 1'b1; stall_mode <= 0; store_mode <= 0;
		force_trig();
		rnd_trig <= 1'b1;
		$display("test qualifier done");
		for (k = 0; k < 6; k++) begin
			use_groups <= 1'b0; top_cfg <= '0; bus_enable <= 1'b0;
			sig_enable <= 8'h01 << k;
			sig_pattern <= 24'(k) << (3 * k);
			run_trig();
		end
		for (k = 0; k < 4; k++) begin
			use_groups <= 1'b0; top_cfg <= '0; sig_enable <= 8'h00; bus_enable <= 1'b1;
			bus_value <= 8'($random(seed)); bus_care <= 8'($random(seed) & $random(seed));
			run_trig();
		end
		$display("test basic trigger done");
		for (k = 0; k < 8; k++) begin
			use_groups <= 1'b1; bus_enable <= 1'b0; sig_enable <= 8'hFF;
			sig_pattern <= 24'($random(seed)); leaf_is_or <= 4'($random(seed));
			leaf_force_en <= 4'($random(seed) & $random(seed)); leaf_force_val <= 4'($random(seed));
			top_cfg <= '{3'(k), 1'b0, 1'b0};
			run_trig();
		end
		rnd_trig <= 1'b0; cyc(10);
		chk_bit("queue drained", 1'b1, exp_q.size() == 0);
		$display("test group trigger done");
		finish_test();
	end
endmodule // tb_capture_qualifier
`default_nettype wire
